// *** core/pmic_regs_pkg.sv ***
// constants and types shared by the power-path, interrupt and charger status register bank
// Notes on behaviour
// - ac current limit codes 100/500/1300/2500 mA, reset 11b
// - usb current limit codes 100/500/1300/1800 mA, reset 01b
// - clearing path enable bits turns inputs off
// - both sink controls high forces both sinks off
// - ac sink on: usb valid, ac below threshold
// - usb sink on: ac valid, usb below threshold
// - button mask high suppresses button interrupt
// - ac mask high suppresses ac interrupt
// - usb mask high suppresses usb interrupt
// - button change flag sets on either edge
// - ac change flag sets on apply or removal
// - usb change flag sets on apply or removal
// - bit 7 reports thermal regulation
// - bit 6 reports load-priority loop active
// - bit 5 reports battery temperature suspend
// - bit 4 reports termination current crossed
// - bit 3 reports charger actively charging
// - bit 2 reports charge timer expired
// - bit 1 reports precharge timer expired
// - bit 0 reports battery temperature fault
package pmic_regs_pkg;

	// register offsets on the serial bus
	localparam logic [7:0] POWER_PATH_CONTROL_OFS    = 8'h01;
	localparam logic [7:0] INTERRUPT_FLAGS_MASKS_OFS = 8'h02;
	localparam logic [7:0] CHARGER_STATUS_OFS        = 8'h03;

	// reset values
	localparam logic [7:0] POWER_PATH_CONTROL_RST    = 8'h3D;
	localparam logic [7:0] INTERRUPT_FLAGS_MASKS_RST = 8'h80;
	localparam logic [7:0] CHARGER_STATUS_RST        = 8'h00;

	// power_path_control fields
	localparam int unsigned AC_SINK_CTL_BIT  = 7;
	localparam int unsigned USB_SINK_CTL_BIT = 6;
	localparam int unsigned AC_PATH_ON_BIT   = 5;
	localparam int unsigned USB_PATH_ON_BIT  = 4;
	localparam int unsigned AC_ILIM_LSB      = 2;
	localparam int unsigned USB_ILIM_LSB     = 0;

	// interrupt_flags_masks fields (bits 6:4 masks, 2:0 flags, 3 reads zero)
	localparam int unsigned MASK_LSB = 4;

	// charger_status fields
	localparam int unsigned THERMAL_LIMIT_FLAG_BIT      = 7;
	localparam int unsigned LOAD_PRIORITY_LOOP_FLAG_BIT = 6;
	localparam int unsigned TEMP_SUSPEND_FLAG_BIT       = 5;
	localparam int unsigned TERM_CURRENT_FLAG_BIT       = 4;
	localparam int unsigned CHARGING_ACTIVE_FLAG_BIT    = 3;
	localparam int unsigned CHARGE_TIMEOUT_FLAG_BIT     = 2;
	localparam int unsigned PRECHARGE_TIMEOUT_FLAG_BIT  = 1;
	localparam int unsigned BATTERY_TEMP_FAULT_BIT      = 0;

	// current limit decode tables, milliamps, indexed by field code
	localparam logic [11:0] AC_ILIM_MA  [0:3] = '{12'h064, 12'h1F4, 12'h514, 12'h9C4};
	localparam logic [11:0] USB_ILIM_MA [0:3] = '{12'h064, 12'h1F4, 12'h514, 12'h708};

	// serial slave states
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
	} i2c_state_t;

endpackage

// *** core/pmic_link_if.sv ***
// bundle carried between the register bank and its two helper modules
`timescale 1ns/1ps
interface pmic_link_if;
	logic        scl;          // synchronised bus clock level
	logic        sda;          // synchronised bus data level
	logic        btn_evt;      // button input changed, one cycle
	logic        ac_evt;       // ac supply applied or removed, one cycle
	logic        usb_evt;      // usb supply applied or removed, one cycle
	logic        ac_valid;     // ac supply valid level
	logic        usb_valid;    // usb supply valid level
	logic        ac_below;     // ac voltage below detection level
	logic        usb_below;    // usb voltage below detection level
	logic [7:0]  chg_status;   // charger status levels
	logic [7:0]  path_cfg;     // power path control register
	logic        ac_path_on;   // ac input switched on
	logic        usb_path_on;  // usb input switched on
	logic        ac_sink_on;   // ac current sink enabled
	logic        usb_sink_on;  // usb current sink enabled
	logic [11:0] ac_ilim_ma;   // ac limit in mA
	logic [11:0] usb_ilim_ma;  // usb limit in mA

	modport sync (output scl, sda, btn_evt, ac_evt, usb_evt, ac_valid, usb_valid,
		ac_below, usb_below, chg_status);
	modport path (input path_cfg, ac_valid, usb_valid, ac_below, usb_below,
		output ac_path_on, usb_path_on, ac_sink_on, usb_sink_on, ac_ilim_ma, usb_ilim_ma);
	modport regs (input scl, sda, btn_evt, ac_evt, usb_evt, chg_status, ac_path_on,
		usb_path_on, ac_sink_on, usb_sink_on, ac_ilim_ma, usb_ilim_ma,
		output path_cfg);
endinterface

// *** core/input_sync.sv ***
// two-stage synchronisers for all pins plus change detection on supply and button levels
`timescale 1ns/1ps
module input_sync #(
	parameter int W = 15  // number of pins synchronised
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pins,
	pmic_link_if.sync         link
);
	// pins order: scl, sda, button, ac valid, usb valid, ac below, usb below, status[7:0]
	typedef struct packed {
		logic [W-1:0] s1;     // first stage, read only by s2
		logic [W-1:0] s2;     // second stage, safe to use
		logic [2:0]   prev;   // last seen button, ac, usb levels
		logic [1:0]   prime;  // counts until s2 and prev hold real pin levels
	} state_t;

	state_t s;
	state_t n;

	// events stay quiet until the chain has filled, so a supply present at reset
	// does not look like a fresh plug-in
	always_comb begin
		n       = s;
		n.s1    = pins;
		n.s2    = s.s1;
		n.prev  = s.s2[12:10];
		if (s.prime != 2'h3) begin
			n.prime = s.prime + 2'h1;
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign link.scl        = s.s2[14];
	assign link.sda        = s.s2[13];
	assign link.btn_evt    = (s.prime == 2'h3) & (s.s2[12] ^ s.prev[2]);
	assign link.ac_evt     = (s.prime == 2'h3) & (s.s2[11] ^ s.prev[1]);
	assign link.usb_evt    = (s.prime == 2'h3) & (s.s2[10] ^ s.prev[0]);
	assign link.ac_valid   = s.s2[11];
	assign link.usb_valid  = s.s2[10];
	assign link.ac_below   = s.s2[9];
	assign link.usb_below  = s.s2[8];
	assign link.chg_status = s.s2[7:0];
endmodule

// *** core/path_ctl.sv ***
// power path switches, current sink enables and current limit decode
`timescale 1ns/1ps
module path_ctl (
	input  wire logic clk,
	input  wire logic rst,
	pmic_link_if.path link
);
	typedef struct packed {
		logic        ac_on;    // ac input switched on
		logic        usb_on;   // usb input switched on
		logic        ac_sink;  // ac sink enabled
		logic        usb_sink; // usb sink enabled
		logic [11:0] ac_ma;    // ac limit
		logic [11:0] usb_ma;   // usb limit
	} state_t;

	localparam logic [7:0] CFG = pmic_regs_pkg::POWER_PATH_CONTROL_RST;
	localparam state_t RST = '{
		ac_on:    CFG[pmic_regs_pkg::AC_PATH_ON_BIT],
		usb_on:   CFG[pmic_regs_pkg::USB_PATH_ON_BIT],
		ac_sink:  1'b0,
		usb_sink: 1'b0,
		ac_ma:    pmic_regs_pkg::AC_ILIM_MA[CFG[pmic_regs_pkg::AC_ILIM_LSB +: 2]],
		usb_ma:   pmic_regs_pkg::USB_ILIM_MA[CFG[pmic_regs_pkg::USB_ILIM_LSB +: 2]]
	};

	state_t     s;
	state_t     n;
	logic       ac_ctl;        // ac sink control bit
	logic       usb_ctl;       // usb sink control bit
	logic [1:0] ac_ilim_sel;   // ac limit code
	logic [1:0] usb_ilim_sel;  // usb limit code

	assign ac_ctl       = link.path_cfg[pmic_regs_pkg::AC_SINK_CTL_BIT];
	assign usb_ctl      = link.path_cfg[pmic_regs_pkg::USB_SINK_CTL_BIT];
	assign ac_ilim_sel  = link.path_cfg[pmic_regs_pkg::AC_ILIM_LSB +: 2];
	assign usb_ilim_sel = link.path_cfg[pmic_regs_pkg::USB_ILIM_LSB +: 2];

	// a sink runs only with its own control bit low; a mixed pair therefore
	// leaves one sink automatic, which is why software must not write it
	always_comb begin
		n          = s;
		n.ac_on    = link.path_cfg[pmic_regs_pkg::AC_PATH_ON_BIT];
		n.usb_on   = link.path_cfg[pmic_regs_pkg::USB_PATH_ON_BIT];
		n.ac_ma    = pmic_regs_pkg::AC_ILIM_MA[ac_ilim_sel];
		n.usb_ma   = pmic_regs_pkg::USB_ILIM_MA[usb_ilim_sel];
		n.ac_sink  = ~ac_ctl & link.usb_valid & link.ac_below;
		n.usb_sink = ~usb_ctl & link.ac_valid & link.usb_below;
		if (ac_ctl & usb_ctl) begin
			n.ac_sink  = 1'b0;
			n.usb_sink = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= RST;
		end else begin
			s <= n;
		end
	end

	assign link.ac_path_on  = s.ac_on;
	assign link.usb_path_on = s.usb_on;
	assign link.ac_sink_on  = s.ac_sink;
	assign link.usb_sink_on = s.usb_sink;
	assign link.ac_ilim_ma  = s.ac_ma;
	assign link.usb_ilim_ma = s.usb_ma;
endmodule

// *** core/power_path_regs.sv ***
// register bank on a two-wire serial bus: power path control, interrupts, charger status
`timescale 1ns/1ps
module power_path_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h2A  // bus address, value arbitrary
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        scl,            // bus clock from host
	input  wire logic        sda_in,         // bus data level
	output logic             sda_out,        // bus data drive value, always low
	output logic             sda_oe,         // high while pulling data low
	input  wire logic        button_input,   // push-button level
	input  wire logic        ac_valid_in,    // ac supply valid
	input  wire logic        usb_valid_in,   // usb supply valid
	input  wire logic        ac_below_in,    // ac voltage below detect level
	input  wire logic        usb_below_in,   // usb voltage below detect level
	input  wire logic [7:0]  chg_status_in,  // charger status levels
	output logic             ac_path_on,     // ac input on
	output logic             usb_path_on,    // usb input on
	output logic             ac_sink_on,     // ac current sink on
	output logic             usb_sink_on,    // usb current sink on
	output logic [11:0]      ac_ilim_ma,     // ac limit, mA
	output logic [11:0]      usb_ilim_ma,    // usb limit, mA
	output logic             irq             // interrupt to host, active high
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	pmic_link_if link ();

	// every pin crosses two flops before use
	input_sync #(
		.W (15)
	) u_sync (
		.clk  (clk),
		.rst  (rst),
		.pins ({scl, sda_in, button_input, ac_valid_in, usb_valid_in,
			ac_below_in, usb_below_in, chg_status_in}),
		.link (link)
	);

	// path switches and sinks follow the control register
	path_ctl u_path (
		.clk  (clk),
		.rst  (rst),
		.link (link)
	);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		pmic_regs_pkg::i2c_state_t st;  // serial slave state
		logic [3:0] cnt;                // bits moved in current byte
		logic [7:0] sh;                 // shift register
		logic [7:0] ptr;                // register pointer
		logic       rw;                 // read transfer
		logic       mack;               // host acknowledged last read byte
		logic       scl_p;              // previous bus clock
		logic       sda_p;              // previous bus data
		logic       oe;                 // pulling data low
		logic       sda_lo;             // drive value, constant low
		logic [7:0] path;               // power path control
		logic [3:0] int_ctl;            // reserved bit and three masks
		logic [2:0] flags;              // button, ac, usb change flags
		logic [7:0] chg;                // charger status image
		logic       irq;                // interrupt line
	} state_t;

	localparam logic [7:0] INT_RST = pmic_regs_pkg::INTERRUPT_FLAGS_MASKS_RST;

	// bus lines idle high, so previous levels reset high to avoid a false start
	localparam state_t RST = '{
		st:      pmic_regs_pkg::ST_IDLE,
		cnt:     4'h0,
		sh:      8'h00,
		ptr:     8'h00,
		rw:      1'b0,
		mack:    1'b0,
		scl_p:   1'b1,
		sda_p:   1'b1,
		oe:      1'b0,
		sda_lo:  1'b0,
		path:    pmic_regs_pkg::POWER_PATH_CONTROL_RST,
		int_ctl: INT_RST[7:4],
		flags:   INT_RST[2:0],
		chg:     pmic_regs_pkg::CHARGER_STATUS_RST,
		irq:     1'b0
	};

	state_t s;
	state_t n;

	////////////////////////////////////////////////////////////////////////////////
	// register read view

	// unmapped offsets and the reserved flag bit read as zero
	function automatic logic [7:0] read_reg(input logic [7:0] a, input state_t v);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			pmic_regs_pkg::POWER_PATH_CONTROL_OFS: begin
				r = v.path;
			end
			pmic_regs_pkg::INTERRUPT_FLAGS_MASKS_OFS: begin
				r = {v.int_ctl, 1'b0, v.flags};
			end
			pmic_regs_pkg::CHARGER_STATUS_OFS: begin
				r = v.chg;
			end
			default: begin
				r = 8'h00;
			end
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic       rise;      // bus clock rising
		logic       fall;      // bus clock falling
		logic       start;     // start or repeated start
		logic       stop;      // stop condition
		logic [7:0] rd;        // byte at pointer
		logic [2:0] clr;       // flags handed to host this cycle
		logic       load;      // fetch next read byte
		rise  = 1'b0;
		fall  = 1'b0;
		start = 1'b0;
		stop  = 1'b0;
		rd    = 8'h00;
		clr   = 3'h0;
		load  = 1'b0;
		n     = s;

		rise    = link.scl & ~s.scl_p;
		fall    = ~link.scl & s.scl_p;
		start   = link.scl & s.scl_p & s.sda_p & ~link.sda;
		stop    = link.scl & s.scl_p & ~s.sda_p & link.sda;
		rd      = read_reg(s.ptr, s);
		n.scl_p = link.scl;
		n.sda_p = link.sda;

		// charger status mirrors the synchronised charger levels
		n.chg[pmic_regs_pkg::THERMAL_LIMIT_FLAG_BIT] =
			link.chg_status[pmic_regs_pkg::THERMAL_LIMIT_FLAG_BIT];
		n.chg[pmic_regs_pkg::LOAD_PRIORITY_LOOP_FLAG_BIT] =
			link.chg_status[pmic_regs_pkg::LOAD_PRIORITY_LOOP_FLAG_BIT];
		n.chg[pmic_regs_pkg::TEMP_SUSPEND_FLAG_BIT] =
			link.chg_status[pmic_regs_pkg::TEMP_SUSPEND_FLAG_BIT];
		n.chg[pmic_regs_pkg::TERM_CURRENT_FLAG_BIT] =
			link.chg_status[pmic_regs_pkg::TERM_CURRENT_FLAG_BIT];
		n.chg[pmic_regs_pkg::CHARGING_ACTIVE_FLAG_BIT] =
			link.chg_status[pmic_regs_pkg::CHARGING_ACTIVE_FLAG_BIT];
		n.chg[pmic_regs_pkg::CHARGE_TIMEOUT_FLAG_BIT] =
			link.chg_status[pmic_regs_pkg::CHARGE_TIMEOUT_FLAG_BIT];
		n.chg[pmic_regs_pkg::PRECHARGE_TIMEOUT_FLAG_BIT] =
			link.chg_status[pmic_regs_pkg::PRECHARGE_TIMEOUT_FLAG_BIT];
		n.chg[pmic_regs_pkg::BATTERY_TEMP_FAULT_BIT] =
			link.chg_status[pmic_regs_pkg::BATTERY_TEMP_FAULT_BIT];

		if (start) begin
			// start aborts anything in flight
			n.st  = pmic_regs_pkg::ST_ADDR;
			n.cnt = 4'h0;
			n.oe  = 1'b0;
		end else if (stop) begin
			// stop releases the bus
			n.st = pmic_regs_pkg::ST_IDLE;
			n.oe = 1'b0;
		end else begin
			case (s.st)
				pmic_regs_pkg::ST_IDLE: begin
					n.oe = 1'b0;
				end
				pmic_regs_pkg::ST_ADDR: begin
					// shift address and direction in on rising clock
					if (rise) begin
						n.sh  = {s.sh[6:0], link.sda};
						n.cnt = s.cnt + 4'h1;
					end else if (fall && s.cnt == 4'h8) begin
						if (s.sh[7:1] == DEV_ADDR) begin
							n.rw = s.sh[0];
							n.oe = 1'b1;
							n.st = pmic_regs_pkg::ST_ADDR_ACK;
						end else begin
							// another device is addressed, keep off the bus
							n.st = pmic_regs_pkg::ST_IDLE;
						end
					end
				end
				pmic_regs_pkg::ST_ADDR_ACK: begin
					// end of acknowledge clock: read starts at pointer
					if (fall) begin
						n.cnt = 4'h0;
						n.oe  = 1'b0;
						if (s.rw) begin
							load = 1'b1;
						end else begin
							n.st = pmic_regs_pkg::ST_PTR;
						end
					end
				end
				pmic_regs_pkg::ST_PTR: begin
					// first written byte sets the pointer
					if (rise) begin
						n.sh  = {s.sh[6:0], link.sda};
						n.cnt = s.cnt + 4'h1;
					end else if (fall && s.cnt == 4'h8) begin
						n.ptr = s.sh;
						n.oe  = 1'b1;
						n.st  = pmic_regs_pkg::ST_PTR_ACK;
					end
				end
				pmic_regs_pkg::ST_PTR_ACK: begin
					if (fall) begin
						n.oe  = 1'b0;
						n.cnt = 4'h0;
						n.st  = pmic_regs_pkg::ST_WDATA;
					end
				end
				pmic_regs_pkg::ST_WDATA: begin
					// data bytes land at pointer, pointer steps after each
					if (rise) begin
						n.sh  = {s.sh[6:0], link.sda};
						n.cnt = s.cnt + 4'h1;
					end else if (fall && s.cnt == 4'h8) begin
						if (s.ptr == pmic_regs_pkg::POWER_PATH_CONTROL_OFS) begin
							n.path = s.sh;
						end else if (s.ptr == pmic_regs_pkg::INTERRUPT_FLAGS_MASKS_OFS) begin
							n.int_ctl = s.sh[7:pmic_regs_pkg::MASK_LSB];
						end
						n.ptr = s.ptr + 8'h01;
						n.oe  = 1'b1;
						n.st  = pmic_regs_pkg::ST_WDATA_ACK;
					end
				end
				pmic_regs_pkg::ST_WDATA_ACK: begin
					if (fall) begin
						n.oe  = 1'b0;
						n.cnt = 4'h0;
						n.st  = pmic_regs_pkg::ST_WDATA;
					end
				end
				pmic_regs_pkg::ST_RDATA: begin
					// next bit goes out on each falling clock
					if (fall) begin
						if (s.cnt == 4'h7) begin
							n.oe = 1'b0;
							n.st = pmic_regs_pkg::ST_RDATA_ACK;
						end else begin
							n.sh  = {s.sh[6:0], 1'b0};
							n.oe  = ~s.sh[6];
							n.cnt = s.cnt + 4'h1;
						end
					end
				end
				pmic_regs_pkg::ST_RDATA_ACK: begin
					// host low means more bytes wanted
					if (rise) begin
						n.mack = ~link.sda;
					end else if (fall) begin
						if (s.mack) begin
							load = 1'b1;
						end else begin
							n.st = pmic_regs_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					n.st = pmic_regs_pkg::ST_IDLE;
					n.oe = 1'b0;
				end
			endcase
		end

		// fetch a byte for the host and drive its first bit at once
		if (load) begin
			n.sh  = rd;
			n.oe  = ~rd[7];
			n.cnt = 4'h0;
			n.ptr = s.ptr + 8'h01;
			n.st  = pmic_regs_pkg::ST_RDATA;
			if (s.ptr == pmic_regs_pkg::INTERRUPT_FLAGS_MASKS_OFS) begin
				// only flags actually seen by the host are cleared
				clr = rd[2:0];
			end
		end

		// a change landing in the clearing cycle survives: set wins
		n.flags = (s.flags & ~clr) | {link.btn_evt, link.ac_evt, link.usb_evt};
		n.irq   = |(n.flags & ~n.int_ctl[2:0]);
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register and outputs

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= RST;
		end else begin
			s <= n;
		end
	end

	// feed control register to the path logic
	assign link.path_cfg = s.path;

	assign sda_out     = s.sda_lo;
	assign sda_oe      = s.oe;
	assign irq         = s.irq;
	assign ac_path_on  = link.ac_path_on;
	assign usb_path_on = link.usb_path_on;
	assign ac_sink_on  = link.ac_sink_on;
	assign usb_sink_on = link.usb_sink_on;
	assign ac_ilim_ma  = link.ac_ilim_ma;
	assign usb_ilim_ma = link.usb_ilim_ma;

endmodule

// *** sim/pp_regs_asserts.sv ***
// port checker for the power path register bank
`timescale 1ns/1ps
module pp_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        scl,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        button_input,
	input wire logic        ac_valid_in,
	input wire logic        usb_valid_in,
	input wire logic        ac_below_in,
	input wire logic        usb_below_in,
	input wire logic [7:0]  chg_status_in,
	input wire logic        ac_path_on,
	input wire logic        usb_path_on,
	input wire logic        ac_sink_on,
	input wire logic        usb_sink_on,
	input wire logic [11:0] ac_ilim_ma,
	input wire logic [11:0] usb_ilim_ma,
	input wire logic        irq
);
	////////
	logic [2:0] lvl_q;   // event input levels last cycle
	logic [3:0] quiet_q; // cycles since an event input moved
	// saturating count, so an irq long after any change is caught
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lvl_q   <= 3'h0;
			quiet_q <= 4'hF;
		end else begin
			lvl_q <= {button_input, ac_valid_in, usb_valid_in};
			if (lvl_q != {button_input, ac_valid_in, usb_valid_in}) begin
				quiet_q <= 4'h0;
			end else if (quiet_q != 4'hF) begin
				quiet_q <= quiet_q + 4'h1;
			end
		end
	end
	////////
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_drive_low_only: assert property (sda_out == 1'b0) else $error("data drive not low");
	a_reset_levels: assert property ($fell(rst) |-> ac_path_on && usb_path_on &&
		ac_ilim_ma == 12'h9C4 && usb_ilim_ma == 12'h1F4 && !irq && !sda_oe)
		else $error("bad levels after reset");
	a_ac_limit_code: assert property (ac_ilim_ma inside {12'h064, 12'h1F4, 12'h514, 12'h9C4})
		else $error("ac limit off table");
	a_usb_limit_code: assert property (usb_ilim_ma inside {12'h064, 12'h1F4, 12'h514, 12'h708})
		else $error("usb limit off table");
	a_ac_sink_supply: assert property (!usb_valid_in [*5] |-> !ac_sink_on)
		else $error("ac sink on without usb");
	a_ac_sink_level: assert property (!ac_below_in [*5] |-> !ac_sink_on)
		else $error("ac sink on above threshold");
	a_usb_sink_supply: assert property (!ac_valid_in [*5] |-> !usb_sink_on)
		else $error("usb sink on without ac");
	a_usb_sink_level: assert property (!usb_below_in [*5] |-> !usb_sink_on)
		else $error("usb sink on above threshold");
	a_data_scl_low: assert property ($changed(sda_oe) |-> !scl) else $error("data moved, scl high");
	a_irq_has_cause: assert property ($rose(irq) |-> quiet_q < 4'h8)
		else $error("irq rose with no input change");
	c_irq_rise: cover property ($rose(irq));
	c_ac_sink: cover property ($rose(ac_sink_on));
	c_ack_drive: cover property ($rose(sda_oe));
endmodule

bind power_path_regs pp_checker chk_u (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .button_input(button_input),
	.ac_valid_in(ac_valid_in), .usb_valid_in(usb_valid_in), .ac_below_in(ac_below_in),
	.usb_below_in(usb_below_in), .chg_status_in(chg_status_in), .ac_path_on(ac_path_on),
	.usb_path_on(usb_path_on), .ac_sink_on(ac_sink_on), .usb_sink_on(usb_sink_on),
	.ac_ilim_ma(ac_ilim_ma), .usb_ilim_ma(usb_ilim_ma), .irq(irq));

// *** sim/i2c_host.sv ***
// two-wire bus host model for the register bank
`timescale 1ns/1ps
module i2c_host (
	input  wire logic clk,
	input  wire logic dev_low,
	output logic      scl,
	output logic      sda
);
	logic       host_low; // host pulls data low
	logic [6:0] dev;      // target address, arbitrary value
	// released wire rises through the pull-up
	assign sda = ~(host_low | dev_low);
	initial begin
		scl = 1'b1;
		host_low = 1'b0;
		dev = 7'h2A;
	end
	////////
	// ten cycles per phase keeps setup and hold well above the two synchroniser stages
	task automatic hw();
		repeat (10) @(negedge clk);
	endtask
	task automatic xb(input logic b, output logic r);
		scl = 1'b0;
		hw();
		host_low = ~b;
		hw();
		scl = 1'b1;
		hw();
		r = sda;
	endtask
	task automatic xbyte(input logic [7:0] b, input logic a, output logic [7:0] r,
		output logic k);
		for (int i = 7; i >= 0; i--) begin
			xb(b[i], r[i]);
		end
		xb(a, k);
	endtask
	task automatic st();
		scl = 1'b0;
		hw();
		host_low = 1'b0;
		hw();
		scl = 1'b1;
		hw();
		host_low = 1'b1;
		hw();
	endtask
	task automatic sp();
		scl = 1'b0;
		hw();
		host_low = 1'b1;
		hw();
		scl = 1'b1;
		hw();
		host_low = 1'b0;
		hw();
	endtask
	////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       k1;
		logic       k2;
		logic       k3;
		st();
		xbyte({dev, 1'b0}, 1'b1, r, k1);
		xbyte(a, 1'b1, r, k2);
		xbyte(d, 1'b1, r, k3);
		sp();
		ok = ~(k1 | k2 | k3);
	endtask
	// single byte read, ended by a nack
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       k1;
		logic       k2;
		logic       k3;
		logic       k4;
		st();
		xbyte({dev, 1'b0}, 1'b1, r, k1);
		xbyte(a, 1'b1, r, k2);
		st();
		xbyte({dev, 1'b1}, 1'b1, r, k3);
		xbyte(8'hFF, 1'b1, d, k4);
		sp();
		ok = ~(k1 | k2 | k3);
	endtask
	// two byte read from one pointer, host acks the first byte to ask for more
	task automatic rd2(input logic [7:0] a, output logic [15:0] d, output logic ok);
		logic [7:0] r;
		logic       k1;
		logic       k2;
		logic       k3;
		logic       k4;
		st();
		xbyte({dev, 1'b0}, 1'b1, r, k1);
		xbyte(a, 1'b1, r, k2);
		st();
		xbyte({dev, 1'b1}, 1'b1, r, k3);
		xbyte(8'hFF, 1'b0, d[15:8], k4);
		xbyte(8'hFF, 1'b1, d[7:0], k4);
		sp();
		ok = ~(k1 | k2 | k3);
	endtask
endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the power path register bank
`timescale 1ns/1ps
module tb_top;
	logic        clk;
	logic        rst;
	logic        scl;
	logic        sda;     // resolved data wire
	logic        sda_out;
	logic        sda_oe;
	logic        btn;
	logic        acv;
	logic        usbv;
	logic        acb;
	logic        usbb;
	logic [7:0]  chg;
	logic        ac_on;
	logic        usb_on;
	logic        ac_snk;
	logic        usb_snk;
	logic        irq;
	logic [11:0] ac_ma;
	logic [11:0] usb_ma;
	logic [7:0]  rv;
	logic [15:0] rv2;     // two byte read result
	logic        ok;
	int          fail_count = 0;
	int          checks = 0;
	logic [11:0] ac_tab [0:3] = '{12'h064, 12'h1F4, 12'h514, 12'h9C4};
	logic [11:0] usb_tab [0:3] = '{12'h064, 12'h1F4, 12'h514, 12'h708};
	power_path_regs dut_u (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .button_input(btn), .ac_valid_in(acv), .usb_valid_in(usbv),
		.ac_below_in(acb), .usb_below_in(usbb), .chg_status_in(chg), .ac_path_on(ac_on),
		.usb_path_on(usb_on), .ac_sink_on(ac_snk), .usb_sink_on(usb_snk),
		.ac_ilim_ma(ac_ma), .usb_ilim_ma(usb_ma), .irq(irq));
	i2c_host host_u (.clk(clk), .dev_low(sda_oe), .scl(scl), .sda(sda));
	////////
	task automatic chk(input string n, input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.wr(a, d, ok);
		chk("write ack", {11'h0, ok}, 12'h001);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host_u.rd(a, rv, ok);
		chk("read ack", {11'h0, ok}, 12'h001);
		chk("read data", {4'h0, rv}, {4'h0, e});
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic end_sim();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	////////
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// hang guard
	initial begin
		repeat (99000) @(posedge clk);
		fail_count++;
		end_sim();
	end
	////////
	initial begin
		rst = 1'b1;
		{btn, acv, usbv, acb, usbb} = 5'h08;
		chg = 8'h00;
		step(5);
		rst = 1'b0;
		step(8);
		chk("ac limit", ac_ma, 12'h9C4);
		chk("usb limit", usb_ma, 12'h1F4);
		chk("levels", {7'h0, ac_on, usb_on, ac_snk, usb_snk, irq}, 12'h018);
		rd(8'h01, 8'h3D);
		rd(8'h02, 8'h80);
		rd(8'h03, 8'h00);
		rd(8'h07, 8'h00);
		// every limit code, both inputs left on
		for (int c = 0; c < 4; c++) begin
			wr(8'h01, {4'h3, c[1:0], c[1:0]});
			step(4);
			chk("ac limit", ac_ma, ac_tab[c]);
			chk("usb limit", usb_ma, usb_tab[c]);
		end
		for (int p = 0; p < 4; p++) begin
			wr(8'h01, {2'b00, p[1:0], 4'hD});
			step(4);
			chk("path on", {10'h0, ac_on, usb_on}, {10'h0, p[1:0]});
		end
		// sinks, control pair only ever 00 or 11
		usbv = 1'b1;
		acb = 1'b1;
		usbb = 1'b1;
		step(8);
		chk("sinks auto", {10'h0, ac_snk, usb_snk}, 12'h003);
		wr(8'h01, 8'hFD);
		step(4);
		chk("sinks forced", {10'h0, ac_snk, usb_snk}, 12'h000);
		wr(8'h01, 8'h3D);
		acb = 1'b0;
		step(8);
		chk("sinks level", {10'h0, ac_snk, usb_snk}, 12'h001);
		usbb = 1'b0;
		// usb supply arrival left its flag pending
		rd(8'h02, 8'h81);
		step(4);
		chk("irq clear", {11'h0, irq}, 12'h000);
		btn = 1'b1;
		step(8);
		chk("irq button", {11'h0, irq}, 12'h001);
		rd(8'h02, 8'h84);
		btn = 1'b0;
		step(8);
		rd(8'h02, 8'h84);
		// all masked: flags still set, no irq
		wr(8'h02, 8'hF0);
		btn = 1'b1;
		acv = 1'b0;
		usbv = 1'b0;
		step(8);
		chk("irq masked", {11'h0, irq}, 12'h000);
		rd(8'h02, 8'hF7);
		wr(8'h02, 8'hD0);
		acv = 1'b1;
		step(8);
		chk("irq ac", {11'h0, irq}, 12'h001);
		rd(8'h02, 8'hD2);
		wr(8'h02, 8'hE0);
		usbv = 1'b1;
		step(8);
		chk("irq usb", {11'h0, irq}, 12'h001);
		rd(8'h02, 8'hE1);
		wr(8'h02, 8'h8F);
		rd(8'h02, 8'h80);
		// each status bit alone
		for (int i = 0; i < 8; i++) begin
			chg = 8'h01 << i;
			step(8);
			rd(8'h03, 8'h01 << i);
		end
		wr(8'h03, 8'hFF);
		rd(8'h03, 8'h80);
		// foreign address is ignored
		host_u.dev = 7'h11;
		host_u.wr(8'h01, 8'h00, ok);
		chk("foreign ack", {11'h0, ok}, 12'h000);
		host_u.dev = 7'h2A;
		rd(8'h01, 8'h3D);
		// burst read: pointer steps to the next register after the acked byte
		host_u.rd2(8'h01, rv2, ok);
		chk("burst ack", {11'h0, ok}, 12'h001);
		chk("burst first", {4'h0, rv2[15:8]}, 12'h03D);
		chk("burst second", {4'h0, rv2[7:0]}, 12'h080);
		end_sim();
	end
endmodule
